// ==== core/lic_pkg.sv ====
// package: constants and carriers for the legacy compatibility checks block
package lic_pkg;

    // flag register bit positions
    localparam int FLAG_NESTED_TASK   = 14;
    localparam int FLAG_IO_PRIV_LO    = 12;
    localparam int FLAG_RSVD15        = 15;
    localparam int FLAG_ALIGN_CHECK   = 18;
    localparam int FLAG_VIRT_INTR     = 19;
    localparam int FLAG_VIRT_PEND     = 20;
    localparam int FLAG_IDENT         = 21;

    // feature presence of this core variant
    localparam logic FEAT_ALIGN_CHECK = 1'b1;
    localparam logic FEAT_VME         = 1'b1;

    // flag register reset value and software-writable bits
    localparam logic [31:0] FLAG_RESET     = 32'h0000_0002;
    localparam logic [31:0] FLAG_FIXED_ONE = 32'h0000_0002;
    localparam logic [31:0] FLAG_BASE_WR   = 32'h0020_7FD5;
    localparam logic [31:0] FLAG_ALIGN_BIT = 32'h0004_0000;
    localparam logic [31:0] FLAG_VM_BITS   = 32'h0018_0000;
    localparam logic [31:0] FLAG_RSVD15_M  = 32'h0000_8000;

    // extended control register
    localparam logic [31:0] EXTCR_RESET    = 32'h0000_0000;
    localparam logic [31:0] EXTCR_RSVD     = 32'hFFFF_F800;

    // opcode encodings
    localparam logic [7:0] OP_TWO_BYTE  = 8'h0F;
    localparam logic [7:0] OP_PUSH_SP   = 8'h54;
    localparam logic [7:0] OP_FLAGS_PSH = 8'h9C;
    localparam logic [7:0] OP_FLAGS_POP = 8'h9D;
    localparam logic [7:0] OP2_IDENT    = 8'hA2;
    localparam logic [7:0] OP2_UNDEF    = 8'h0B;
    localparam logic [7:0] OP2_TEST_RD  = 8'h24;
    localparam logic [7:0] OP2_TEST_WR  = 8'h26;
    localparam logic [7:0] OP2_CTRL_WR  = 8'h22;
    localparam logic [2:0] CR_EXT_SEL   = 3'h4;
    localparam logic [31:0] SP_STEP     = 32'h0000_0004;

    // identification results
    localparam logic [31:0] IDENT_MAX_LEAF = 32'h0000_0001;
    localparam logic [3:0]  IDENT_FAMILY   = 4'h6;
    localparam int          IDENT_FAM_LO   = 8;
    localparam int          FEAT_FPU       = 0;
    localparam int          FEAT_TSC       = 4;
    localparam int          FEAT_MSR       = 5;
    localparam int          FEAT_CX8       = 8;
    localparam int          FEAT_CMOV      = 15;
    localparam int          FEAT_SIMD      = 23;

    // register port offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CLEAR  = 8'h04;
    localparam logic [7:0] REG_ENABLE = 8'h08;
    localparam logic [7:0] REG_FLAGS  = 8'h0C;
    localparam logic [7:0] REG_EXTCR  = 8'h10;

    // event bits in status, clear and enable
    localparam int EV_UD   = 0;
    localparam int EV_GP   = 1;
    localparam int EV_W    = 2;

    // one instruction presented to the checks
    typedef struct packed {
        logic        valid;
        logic [7:0]  op0;
        logic [7:0]  op1;
        logic [7:0]  modrm;
        logic [31:0] operand;
    } lic_instr_t;

    // registered outcome of one instruction
    typedef struct packed {
        logic        valid;
        logic        ud;
        logic        gp;
        logic        commit;
        logic        mem_wr;
        logic [31:0] mem_data;
        logic [31:0] sp_new;
        logic        sp_wr;
        logic        ident_wr;
        logic [31:0] ident_a;
        logic [31:0] ident_d;
    } lic_result_t;

endpackage

// ==== core/lic_flags.sv ====
// flag register with per-variant writable bits
`timescale 1ns/1ps
module lic_flags (
    input  wire logic        clk_i,     // core clock
    input  wire logic        srst_i,    // sync reset, active high
    input  wire logic        load_i,    // load from software
    input  wire logic [31:0] data_i,    // value to load
    output logic      [31:0] flags_o,   // current flag register
    output logic      [31:0] image_o    // image for stack pushes
);

    logic [31:0] flag_register;
    logic [31:0] wr_mask;
    logic [31:0] next_flags;

    // absent features never take a one, so they read back clear
    assign wr_mask = lic_pkg::FLAG_BASE_WR
                   | (lic_pkg::FEAT_ALIGN_CHECK ? lic_pkg::FLAG_ALIGN_BIT
                                                : 32'h0000_0000)
                   | (lic_pkg::FEAT_VME ? lic_pkg::FLAG_VM_BITS
                                        : 32'h0000_0000);

    // ident bit sits in the base mask so software can toggle it
    assign next_flags = (data_i & wr_mask)
                      | lic_pkg::FLAG_FIXED_ONE;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flag_register <= lic_pkg::FLAG_RESET;
        end else if (load_i) begin
            flag_register <= next_flags;
        end
    end

    assign flags_o = flag_register;
    // bit 15 forced clear, io privilege and nested task as last loaded
    assign image_o = flag_register & ~lic_pkg::FLAG_RSVD15_M;

endmodule

// ==== core/lic_top.sv ====
// instruction compatibility checks: decode faults, flags, stack, ident
`timescale 1ns/1ps
module lic_top (
    input  wire logic                 clk_i,        // core clock, 25 MHz
    input  wire logic                 srst_i,       // sync reset, active high
    input  wire lic_pkg::lic_instr_t  instr_i,      // instruction presented
    input  wire logic [31:0]          sp_i,         // current stack pointer
    input  wire logic                 real_mode_i,  // real-address mode
    output lic_pkg::lic_result_t      result_o,     // outcome, one cycle later
    output logic [31:0]               flags_o,      // flag register value
    output logic [31:0]               flag_image_o, // image for int pushes
    output logic [31:0]               extcr_o,      // extended control reg
    input  wire logic [7:0]           reg_addr_i,   // register address
    input  wire logic [31:0]          reg_wdata_i,  // register write data
    input  wire logic                 reg_wr_i,     // register write strobe
    input  wire logic                 reg_rd_i,     // register read strobe
    output logic [31:0]               reg_rdata_o,  // read data, next cycle
    output logic                      irq_o         // level interrupt
);

    // reserved second bytes of the two-byte map, test moves excluded
    function automatic logic is_reserved_2b(input logic [7:0] op);
        logic r;
        r = 1'b0;
        unique case (op)
            8'h04, 8'h0A, 8'h0C, 8'h0E, 8'h25, 8'h27: r = 1'b1;
            8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B: r = 1'b1;
            8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'hFF:        r = 1'b1;
            default:                                  r = 1'b0;
        endcase
        return r;
    endfunction

    // a single bit placed at a position of a 32-bit word
    function automatic logic [31:0] bit_at(input int pos);
        return 32'h0000_0001 << pos;
    endfunction

    // decode of the presented instruction
    logic        two_byte;
    logic        dec_reserved;
    logic        dec_test_mov;
    logic        dec_undef;
    logic        dec_ud;
    logic        dec_push_sp;
    logic        dec_flags_push;
    logic        dec_flags_pop;
    logic        dec_ident;
    logic        dec_extcr_wr;
    logic        dec_gp;
    logic        no_fault;

    assign two_byte     = instr_i.op0 == lic_pkg::OP_TWO_BYTE;
    assign dec_reserved = two_byte && is_reserved_2b(instr_i.op1);
    assign dec_test_mov = two_byte
                       && (instr_i.op1 == lic_pkg::OP2_TEST_RD
                        || instr_i.op1 == lic_pkg::OP2_TEST_WR);
    assign dec_undef    = two_byte && instr_i.op1 == lic_pkg::OP2_UNDEF;
    assign dec_ud       = instr_i.valid
                       && (dec_reserved || dec_test_mov || dec_undef);
    assign dec_push_sp  = !two_byte && instr_i.op0 == lic_pkg::OP_PUSH_SP;
    assign dec_flags_push = !two_byte && instr_i.op0 == lic_pkg::OP_FLAGS_PSH;
    assign dec_flags_pop  = !two_byte && instr_i.op0 == lic_pkg::OP_FLAGS_POP;
    assign dec_ident    = two_byte && instr_i.op1 == lic_pkg::OP2_IDENT;
    assign dec_extcr_wr = two_byte && instr_i.op1 == lic_pkg::OP2_CTRL_WR
                       && instr_i.modrm[5:3] == lic_pkg::CR_EXT_SEL;

    // extended control register and its reserved-bit guard
    logic [31:0] ext_control;
    logic        rsvd_change;

    assign rsvd_change = |((instr_i.operand ^ ext_control)
                           & lic_pkg::EXTCR_RSVD);
    assign dec_gp      = instr_i.valid && dec_extcr_wr && rsvd_change;

    // a faulting instruction is held off from every state update except the sticky event status
    assign no_fault = instr_i.valid && !dec_ud && !dec_gp;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ext_control <= lic_pkg::EXTCR_RESET;
        end else if (no_fault && dec_extcr_wr) begin
            ext_control <= instr_i.operand;
        end
    end

    // flag register, loaded by a flags pop that did not fault
    logic [31:0] flag_value;
    logic [31:0] flag_image;
    logic        flag_load;

    assign flag_load = no_fault && dec_flags_pop;

    lic_flags u_flags (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .load_i  (flag_load),
        .data_i  (instr_i.operand),
        .flags_o (flag_value),
        .image_o (flag_image)
    );

    // identification results for the supported leaves
    logic [31:0] feat_d;
    logic [31:0] leaf1_a;
    logic [31:0] next_ident_a;
    logic [31:0] next_ident_d;

    assign feat_d = bit_at(lic_pkg::FEAT_CMOV)
                  | bit_at(lic_pkg::FEAT_CX8)
                  | bit_at(lic_pkg::FEAT_TSC)
                  | bit_at(lic_pkg::FEAT_MSR)
                  | bit_at(lic_pkg::FEAT_SIMD)
                  | bit_at(lic_pkg::FEAT_FPU);
    assign leaf1_a = {20'h0_0000, lic_pkg::IDENT_FAMILY, 8'h00};
    assign next_ident_a = (instr_i.operand == 32'h0000_0000)
                        ? lic_pkg::IDENT_MAX_LEAF
                        : (instr_i.operand == 32'h0000_0001) ? leaf1_a
                        : 32'h0000_0000;
    assign next_ident_d = (instr_i.operand == 32'h0000_0001)
                        ? feat_d : 32'h0000_0000;

    // stack data: pre-decrement pointer, or the real-mode flag image
    logic [31:0] next_mem_data;
    logic        next_mem_wr;
    logic [31:0] next_sp;

    assign next_mem_data = dec_push_sp ? sp_i
                         : flag_image;
    assign next_mem_wr   = no_fault && (dec_push_sp || dec_flags_push);
    assign next_sp       = sp_i - lic_pkg::SP_STEP;

    // registered outcome; faults leave every write strobe low
    lic_pkg::lic_result_t res;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            res <= '0;
        end else begin
            res.valid    <= instr_i.valid;
            res.ud       <= dec_ud;
            res.gp       <= dec_gp;
            res.commit   <= no_fault;
            res.mem_wr   <= next_mem_wr;
            res.mem_data <= next_mem_data;
            res.sp_wr    <= next_mem_wr;
            res.sp_new   <= next_sp;
            res.ident_wr <= no_fault && dec_ident;
            res.ident_a  <= next_ident_a;
            res.ident_d  <= next_ident_d;
        end
    end

    assign result_o     = res;
    assign flags_o      = flag_value;
    assign flag_image_o = real_mode_i ? flag_image : flag_value;
    assign extcr_o      = ext_control;

    // register port decode
    logic sel_clear;
    logic sel_enable;

    assign sel_clear  = reg_wr_i && reg_addr_i == lic_pkg::REG_CLEAR;
    assign sel_enable = reg_wr_i && reg_addr_i == lic_pkg::REG_ENABLE;

    // sticky events; a new event beats a clear in the same cycle
    logic [lic_pkg::EV_W-1:0] ev_status;
    logic [lic_pkg::EV_W-1:0] ev_enable;
    logic [lic_pkg::EV_W-1:0] ev_set;
    logic [lic_pkg::EV_W-1:0] ev_clr;

    assign ev_set = {dec_gp, dec_ud};
    assign ev_clr = sel_clear ? reg_wdata_i[lic_pkg::EV_W-1:0]
                              : {lic_pkg::EV_W{1'b0}};

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ev_status <= '0;
            ev_enable <= '0;
        end else begin
            ev_status <= (ev_status & ~ev_clr) | ev_set;
            if (sel_enable) begin
                ev_enable <= reg_wdata_i[lic_pkg::EV_W-1:0];
            end
        end
    end

    assign irq_o = |(ev_status & ev_enable);

    // read mux; write-only and unmapped addresses read zero
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (reg_addr_i)
            lic_pkg::REG_STATUS: next_rdata = {30'h0, ev_status};
            lic_pkg::REG_ENABLE: next_rdata = {30'h0, ev_enable};
            lic_pkg::REG_FLAGS:  next_rdata = flag_value;
            lic_pkg::REG_EXTCR:  next_rdata = ext_control;
            default:             next_rdata = 32'h0000_0000;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0000_0000;
        end
    end

endmodule

// ==== dv/lic_chk.sv ====
// checker: port-level assertions for the compatibility checks block
`timescale 1ns/1ps
module lic_chk (
    input wire logic                 clk_i,        // core clock
    input wire logic                 srst_i,       // sync reset
    input wire lic_pkg::lic_instr_t  instr_i,      // instruction presented
    input wire logic [31:0]          sp_i,         // stack pointer
    input wire logic                 real_mode_i,  // real-address mode
    input wire lic_pkg::lic_result_t result_o,     // outcome
    input wire logic [31:0]          flags_o,      // flag register
    input wire logic [31:0]          flag_image_o, // pushed image
    input wire logic [31:0]          extcr_o       // extended control reg
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // decode shorthands for the two-byte opcode space
    wire two_b = instr_i.valid && instr_i.op0 == lic_pkg::OP_TWO_BYTE;
    wire rsv_op = two_b && (instr_i.op1 inside
        {8'h04, 8'h0A, 8'h0C, 8'h0E, 8'h25, 8'h27, [8'h36:8'h3F], 8'hFF});
    wire ext_wr = two_b && instr_i.op1 == lic_pkg::OP2_CTRL_WR
        && instr_i.modrm[5:3] == lic_pkg::CR_EXT_SEL;

    a_answer_late: assert property (instr_i.valid |=> result_o.valid)
        else $error("result missing one cycle after instruction");
    a_reserved_ud: assert property (rsv_op |=> result_o.ud)
        else $error("reserved opcode without invalid-opcode");
    a_test_move_ud: assert property (two_b
        && (instr_i.op1 == 8'h24 || instr_i.op1 == 8'h26)
        |=> result_o.ud)
        else $error("test register move not refused");
    a_ud_no_effect: assert property (result_o.ud |->
        !result_o.commit && !result_o.mem_wr && !result_o.sp_wr
        && !result_o.ident_wr)
        else $error("refused instruction left side effects");
    a_ud_keeps_flags: assert property (two_b
        && instr_i.op1 == lic_pkg::OP2_UNDEF |=> $stable(flags_o))
        else $error("flags changed by refused instruction");
    a_push_sp_old: assert property (instr_i.valid
        && instr_i.op0 == lic_pkg::OP_PUSH_SP
        |=> result_o.mem_data == $past(sp_i)
        && result_o.sp_new == $past(sp_i) - 32'h0000_0004)
        else $error("stack pointer push stored wrong value");
    a_ident_bits: assert property (two_b && instr_i.op1 == 8'hA2
        && instr_i.operand == 32'h1 |=> result_o.ident_d == 32'h0080_8131
        && result_o.ident_a[11:8] == 4'h6)
        else $error("identification feature bits wrong");
    a_image_rsvd15: assert property (real_mode_i |->
        !flag_image_o[15] && flag_image_o[14:12] == flags_o[14:12])
        else $error("real mode flag image wrong");
    a_extcr_gp: assert property (ext_wr
        && ((instr_i.operand ^ extcr_o) & lic_pkg::EXTCR_RSVD) != 32'h0
        |=> result_o.gp && $stable(extcr_o))
        else $error("reserved control bit change not refused");
endmodule

bind lic_top lic_chk u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .instr_i(instr_i), .sp_i(sp_i), .real_mode_i(real_mode_i),
    .result_o(result_o), .flags_o(flags_o), .flag_image_o(flag_image_o),
    .extcr_o(extcr_o));

// ==== dv/test_legacy_isa_compat_checks.sv ====
// testbench for the legacy compatibility checks block
`timescale 1ns/1ps
module test_legacy_isa_compat_checks;
    localparam logic [31:0] FM = lic_pkg::FLAG_BASE_WR
        | lic_pkg::FLAG_ALIGN_BIT | lic_pkg::FLAG_VM_BITS;
    logic                 clk_i, srst_i, real_mode_i, reg_wr_i, reg_rd_i;
    logic                 irq_o;
    logic                 rd_d = 1'b0;
    logic [7:0]           reg_addr_i;
    logic [31:0]          sp_i, flags_o, flag_image_o, extcr_o, reg_rdata_o;
    logic [31:0]          reg_wdata_i, lf, op, fe;
    lic_pkg::lic_instr_t  instr_i;
    lic_pkg::lic_result_t result_o, ex;
    lic_pkg::lic_result_t q[$];
    logic [31:0]          rq[$];
    logic [7:0]           rsv[12] = '{8'h04, 8'h0A, 8'h0C, 8'h0E, 8'h25,
        8'h27, 8'h36, 8'h3F, 8'hFF, 8'h24, 8'h26, 8'h0B};
    int                   err_count = 0;
    int                   n_checks = 0;

    lic_top uut (.clk_i(clk_i), .srst_i(srst_i), .instr_i(instr_i),
        .sp_i(sp_i), .real_mode_i(real_mode_i), .result_o(result_o),
        .flags_o(flags_o), .flag_image_o(flag_image_o), .extcr_o(extcr_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    function automatic logic [31:0] nxt(input logic [31:0] l);
        return {l[30:0], 1'b0} ^ (l[31] ? 32'h0040_0007 : 32'h0);
    endfunction
    // f packs ud, gp, commit, mem_wr, sp_wr, ident_wr
    function automatic lic_pkg::lic_result_t mk(input logic [5:0] f,
        input logic [31:0] md, sn, a, d);
        mk = '0;
        {mk.ud, mk.gp, mk.commit, mk.mem_wr, mk.sp_wr, mk.ident_wr} = f;
        mk.mem_data = md;
        mk.sp_new = sn;
        mk.ident_a = a;
        mk.ident_d = d;
    endfunction
    // sp rides with its instruction so back-to-back pushes stay paired
    task automatic ex_i(input logic [7:0] b0, b1, m,
        input logic [31:0] o, s, input lic_pkg::lic_result_t e);
        @(posedge clk_i);
        instr_i <= '{1'b1, b0, b1, m, o};
        sp_i <= s;
        q.push_back(e);
    endtask
    task automatic idle();
        @(posedge clk_i);
        instr_i <= '0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        {reg_rd_i, reg_addr_i} <= {1'b1, a};
        rq.push_back(e);
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // watchdog sized well above the hundred-odd cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        summarize();
    end
    // monitor: sees pre-edge values, so each result is read in its cycle
    always @(posedge clk_i) begin
        rd_d <= reg_rd_i;
        if (rd_d) chk("rdata", rq.pop_front(), reg_rdata_o);
        if (result_o.valid === 1'b1 && q.size() == 0) chk("extra", 0, 1);
        else if (result_o.valid === 1'b1) begin
            ex = q.pop_front();
            // all six strobes, so a stray write is caught as well
            chk("strobes", {ex.ud, ex.gp, ex.commit, ex.mem_wr,
                ex.sp_wr, ex.ident_wr}, {result_o.ud, result_o.gp,
                result_o.commit, result_o.mem_wr, result_o.sp_wr,
                result_o.ident_wr});
            if (ex.ud | ex.gp) chk("side effects", 0, {result_o.mem_wr,
                result_o.sp_wr, result_o.ident_wr});
            if (ex.mem_wr) chk("mem", ex.mem_data, result_o.mem_data);
            if (ex.sp_wr) chk("sp", ex.sp_new, result_o.sp_new);
            if (ex.ident_wr) chk("ident a", ex.ident_a, result_o.ident_a);
            if (ex.ident_wr) chk("ident d", ex.ident_d, result_o.ident_d);
        end
    end

    initial begin
        {srst_i, real_mode_i, reg_wr_i, reg_rd_i} = 4'b1000;
        {instr_i, sp_i, reg_addr_i, reg_wdata_i} = '0;
        lf = 32'h72ce;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(lic_pkg::REG_FLAGS, lic_pkg::FLAG_RESET);
        rd(lic_pkg::REG_ENABLE, 32'h0);
        foreach (rsv[i]) begin
            lf = nxt(lf);
            ex_i(8'h0F, rsv[i], lf[7:0], lf, lf,
                mk(6'h20, 0, 0, 0, 0));
        end
        idle();
        rd(lic_pkg::REG_STATUS, 32'h1);
        @(negedge clk_i) chk("irq masked", 0, irq_o);
        wr(lic_pkg::REG_ENABLE, 32'h3);
        @(negedge clk_i) chk("irq on", 1, irq_o);
        wr(lic_pkg::REG_CLEAR, 32'h1);
        @(negedge clk_i) chk("irq off", 0, irq_o);
        wr(lic_pkg::REG_STATUS, 32'h3);
        rd(lic_pkg::REG_STATUS, 32'h0);
        rd(lic_pkg::REG_CLEAR, 32'h0);
        rd(8'h40, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lf = nxt(lf);
            ex_i(lic_pkg::OP_PUSH_SP, 0, 0, 0, lf,
                mk(6'h0E, lf, lf - lic_pkg::SP_STEP, 0, 0));
        end
        idle();
        for (int i = 0; i < 4; i++) begin
            lf = nxt(lf);
            // bits 12-14 random; bit 15 is offered but must not stick
            op = lf | 32'h0000_8000;
            op[21] = i[0];
            fe = (op & FM) | lic_pkg::FLAG_FIXED_ONE;
            ex_i(lic_pkg::OP_FLAGS_POP, 0, 0, op, 0, mk(6'h08, 0, 0, 0, 0));
            real_mode_i <= i[1];
            ex_i(8'h0F, 8'h0B, 0, ~op, 0, mk(6'h20, 0, 0, 0, 0));
            ex_i(lic_pkg::OP_FLAGS_PSH, 0, 0, 0, 0,
                mk(6'h0E, fe & ~32'h8000, 32'h0 - lic_pkg::SP_STEP, 0, 0));
            idle();
            rd(lic_pkg::REG_FLAGS, fe);
            @(negedge clk_i) chk("flags", fe, flags_o);
            chk("image", i[1] ? fe & ~32'h8000 : fe,
                flag_image_o);
        end
        ex_i(8'h0F, 8'hA2, 0, 0, 0, mk(6'h09, 0, 0, 32'h1, 0));
        ex_i(8'h0F, 8'hA2, 0, 1, 0,
            mk(6'h09, 0, 0, 32'h600, 32'h0080_8131));
        ex_i(8'h0F, 8'hA2, 0, 2, 0, mk(6'h09, 0, 0, 0, 0));
        ex_i(8'h0F, 8'h22, 8'hE0, 32'h800, 0,
            mk(6'h10, 0, 0, 0, 0));
        ex_i(8'h0F, 8'h22, 8'hE0, 32'h1, 0, mk(6'h08, 0, 0, 0, 0));
        ex_i(8'h0F, 8'h22, 8'hE0, 32'hFFFF_F801, 0,
            mk(6'h10, 0, 0, 0, 0));
        idle();
        rd(lic_pkg::REG_EXTCR, 32'h1);
        @(negedge clk_i) chk("extcr", 32'h1, extcr_o);
        rd(lic_pkg::REG_STATUS, 32'h3);
        @(negedge clk_i) chk("irq both", 1, irq_o);
        repeat (3) @(posedge clk_i);
        chk("queues empty", 0, q.size() + rq.size());
        summarize();
    end
endmodule
